// ===== hdl/lsd_pkg.sv
// Summary of operation
// RULE_01: A zero bit drives the line high for the zero-bit high time, default 300 ns.
// RULE_02: A zero bit then drives the line low for the zero-bit low time, default 800 ns.
// RULE_03: A one bit drives the line high for the one-bit high time, default 800 ns.
// RULE_04: A one bit then drives the line low for the one-bit low time, default 300 ns.
// RULE_05: Each frame ends with the line low for the latch time, default 300 ns.
// RULE_06: With pixel gap enabled, a low interval separates two successive pixels.
// RULE_07: With frame gap enabled, extra low time follows latch, except after first frame.
// RULE_08: Every interval is programmed in whole steps of 25 ns.
// RULE_09: Pixel gap and frame gap are both disabled after reset.
// RULE_10: Pixel bits leave serially on one line, coded only by pulse timing.
// RULE_11: Intervals count 25 ns ticks; bit times 8, latch 14, pixel gap 9 bits.
// RULE_12: Line stays low when idle; pixels go out most significant bit first.
package lsd_pkg;

    // ========================================
    // Timing
    localparam int TICK_NS = 25;
    localparam int CLK_NS  = 50;
    localparam int TPC     = CLK_NS / TICK_NS;

    localparam int DEF_T0H_NS   = 300;
    localparam int DEF_T0L_NS   = 800;
    localparam int DEF_T1H_NS   = 800;
    localparam int DEF_T1L_NS   = 300;
    localparam int DEF_LATCH_NS = 300;
    localparam int DEF_PGAP_NS  = 25;
    localparam int DEF_FGAP_NS  = 25;

    // ========================================
    // Widths
    localparam int BIT_W   = 8;
    localparam int LATCH_W = 14;
    localparam int PGAP_W  = 9;
    localparam int FGAP_W  = 31;
    localparam int LEN_W   = 16;
    localparam int PIX_W   = 24;
    localparam int ADR_W   = 8;

    // ========================================
    // Register map
    localparam logic [ADR_W-1:0] REG_CTRL  = 8'h00;
    localparam logic [ADR_W-1:0] REG_BITT  = 8'h04;
    localparam logic [ADR_W-1:0] REG_LATCH = 8'h08;
    localparam logic [ADR_W-1:0] REG_PGAP  = 8'h0C;
    localparam logic [ADR_W-1:0] REG_FGAP  = 8'h10;
    localparam logic [ADR_W-1:0] REG_DATA  = 8'h14;
    localparam logic [ADR_W-1:0] REG_STAT  = 8'h18;
    localparam logic [ADR_W-1:0] REG_FLEN  = 8'h1C;

    localparam int CTRL_EN   = 0;
    localparam int CTRL_PGAP = 1;
    localparam int CTRL_FGAP = 2;
    localparam int F_T0H     = 0;
    localparam int F_T0L     = 8;
    localparam int F_T1H     = 16;
    localparam int F_T1L     = 24;
    localparam int ST_BUSY   = 0;
    localparam int ST_EMPTY  = 1;
    localparam int ST_FULL   = 2;
    localparam int ST_FIRST  = 3;

    typedef struct packed {
        logic               en;
        logic               pgap_en;
        logic               fgap_en;
        logic [BIT_W-1:0]   t0h;
        logic [BIT_W-1:0]   t0l;
        logic [BIT_W-1:0]   t1h;
        logic [BIT_W-1:0]   t1l;
        logic [LATCH_W-1:0] latch;
        logic [PGAP_W-1:0]  pgap;
        logic [FGAP_W-1:0]  fgap;
        logic [LEN_W-1:0]   flen;
    } lsd_cfg_type;

    localparam lsd_cfg_type CFG_RESET = '{
        en:      1'h0,
        pgap_en: 1'h0,
        fgap_en: 1'h0,
        t0h:     BIT_W'(DEF_T0H_NS / TICK_NS),
        t0l:     BIT_W'(DEF_T0L_NS / TICK_NS),
        t1h:     BIT_W'(DEF_T1H_NS / TICK_NS),
        t1l:     BIT_W'(DEF_T1L_NS / TICK_NS),
        latch:   LATCH_W'(DEF_LATCH_NS / TICK_NS),
        pgap:    PGAP_W'(DEF_PGAP_NS / TICK_NS),
        fgap:    FGAP_W'(DEF_FGAP_NS / TICK_NS),
        flen:    16'h0001
    };

    typedef enum logic [6:0] {
        S_IDLE  = 7'h01,
        S_HIGH  = 7'h02,
        S_LOW   = 7'h04,
        S_PGAP  = 7'h08,
        S_FETCH = 7'h10,
        S_LATCH = 7'h20,
        S_FGAP  = 7'h40
    } lsd_state_type;

    // Clock cycles an interval of so many ticks lasts; zero acts as one
    function automatic logic [31:0] cyc_of(input logic [31:0] ticks);
        if (ticks == 32'h0)
            return 32'h1;
        return (ticks + 32'(TPC) - 32'h1) / 32'(TPC);
    endfunction

    function automatic logic [31:0] sel_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction

endpackage

// ===== hdl/lsd_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module lsd_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             s_valid_i,
    output logic                  s_ready_o,
    input  wire logic [WIDTH-1:0] s_data_i,
    output logic                  m_valid_o,
    input  wire logic             m_ready_i,
    output logic      [WIDTH-1:0] m_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic [WIDTH-1:0] head_ff;
    logic             push;
    logic             pop;
    logic [AW-1:0]    nxt_rd;

    assign s_ready_o = cnt_ff != (AW+1)'(DEPTH);
    assign m_valid_o = cnt_ff != '0;
    assign m_data_o  = head_ff;
    assign push      = s_valid_i & s_ready_o;
    assign pop       = m_ready_i & m_valid_o;
    assign nxt_rd    = pop ? rd_ff + AW'(1) : rd_ff;

    always_ff @(posedge clk_i) begin
        if (push)
            mem_ff[wr_ff] <= s_data_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= push ? wr_ff + AW'(1) : wr_ff;
            rd_ff  <= nxt_rd;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // ========================================
    // Head register; bypass when the written slot becomes the head
    always_ff @(posedge clk_i) begin
        if (rst_i)
            head_ff <= '0;
        else if (push && wr_ff == nxt_rd)
            head_ff <= s_data_i;
        else
            head_ff <= mem_ff[nxt_rd];
    end
endmodule
`default_nettype wire

// ===== hdl/lsd_led_strip_driver.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module lsd_led_strip_driver import lsd_pkg::*; #(
    parameter int PIXEL_W    = PIX_W,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output logic                  led_data_o
);
    localparam int BC_W = $clog2(PIXEL_W + 1);

    lsd_cfg_type      cfg_ff;
    lsd_state_type    state_ff;
    lsd_state_type    nxt_state;
    logic             ack_ff;
    logic [31:0]      rd_ff;
    logic             dout_ff;
    logic [31:0]      tick_ff;
    logic [PIXEL_W-1:0] shreg_ff;
    logic [BC_W-1:0]  bits_ff;
    logic [LEN_W-1:0] pix_ff;
    logic             first_ff;
    logic             req;
    logic             data_wr;
    logic             take;
    logic             push;
    logic             fifo_rdy;
    logic             fifo_vld;
    logic [PIXEL_W-1:0] fifo_dat;
    logic             pop;
    logic [31:0]      rd_mux;
    logic [31:0]      wmerged;
    logic [31:0]      target;
    logic             done;
    logic             cur_bit;

    assign wb_ack_o   = ack_ff;
    assign wb_dat_o   = rd_ff;
    assign led_data_o = dout_ff;
    assign cur_bit    = shreg_ff[PIXEL_W-1];

    // ========================================
    // Wishbone slave
    assign req     = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign data_wr = req & wb_we_i & (wb_adr_i == REG_DATA) & (|wb_sel_i);
    // Writes to a full FIFO are stalled by withholding ack
    assign take    = req & ~(data_wr & ~fifo_rdy);
    assign push    = data_wr & fifo_rdy;

    always_comb begin
        case (wb_adr_i)
            REG_CTRL:  rd_mux = {29'h0, cfg_ff.fgap_en, cfg_ff.pgap_en, cfg_ff.en};
            REG_BITT:  rd_mux = {cfg_ff.t1l, cfg_ff.t1h, cfg_ff.t0l, cfg_ff.t0h};
            REG_LATCH: rd_mux = 32'(cfg_ff.latch);
            REG_PGAP:  rd_mux = 32'(cfg_ff.pgap);
            REG_FGAP:  rd_mux = 32'(cfg_ff.fgap);
            REG_STAT:  rd_mux = {28'h0, first_ff, ~fifo_rdy, ~fifo_vld,
                                 state_ff != S_IDLE};
            REG_FLEN:  rd_mux = 32'(cfg_ff.flen);
            default:   rd_mux = 32'h0;
        endcase
    end

    assign wmerged = sel_merge(rd_mux, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            rd_ff  <= 32'h0;
        end else begin
            ack_ff <= take;
            rd_ff  <= (take && !wb_we_i) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_ff <= CFG_RESET; // [RULE_09]
        end else if (take && wb_we_i) begin
            case (wb_adr_i)
                REG_CTRL: begin
                    cfg_ff.en      <= wmerged[CTRL_EN];
                    cfg_ff.pgap_en <= wmerged[CTRL_PGAP];
                    cfg_ff.fgap_en <= wmerged[CTRL_FGAP];
                end
                REG_BITT: begin
                    cfg_ff.t0h <= wmerged[F_T0H +: BIT_W]; // [RULE_11]
                    cfg_ff.t0l <= wmerged[F_T0L +: BIT_W];
                    cfg_ff.t1h <= wmerged[F_T1H +: BIT_W];
                    cfg_ff.t1l <= wmerged[F_T1L +: BIT_W];
                end
                REG_LATCH: cfg_ff.latch <= wmerged[LATCH_W-1:0];
                REG_PGAP:  cfg_ff.pgap  <= wmerged[PGAP_W-1:0];
                REG_FGAP:  cfg_ff.fgap  <= wmerged[FGAP_W-1:0];
                REG_FLEN:  cfg_ff.flen  <= wmerged[LEN_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Pixels queue here so software can run ahead of the line
    lsd_fifo #(
        .WIDTH (PIXEL_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .s_valid_i (push),
        .s_ready_o (fifo_rdy),
        .s_data_i  (wb_dat_i[PIXEL_W-1:0]),
        .m_valid_o (fifo_vld),
        .m_ready_i (pop),
        .m_data_o  (fifo_dat)
    );

    // ========================================
    // Waveform sequencer
    // Intervals are held in 25 ns ticks; one clock is TPC ticks, so odd
    // counts round up to a whole clock
    always_comb begin
        case (state_ff)
            S_HIGH:  target = 32'(cur_bit ? cfg_ff.t1h : cfg_ff.t0h); // [RULE_01] [RULE_03]
            S_LOW:   target = 32'(cur_bit ? cfg_ff.t1l : cfg_ff.t0l); // [RULE_02] [RULE_04]
            S_PGAP:  target = 32'(cfg_ff.pgap);
            S_LATCH: target = 32'(cfg_ff.latch); // [RULE_05]
            S_FGAP:  target = 32'(cfg_ff.fgap);
            default: target = 32'h0;
        endcase
    end

    assign done = ({1'b0, tick_ff} + 33'(TPC)) >= {1'b0, target}; // [RULE_08]

    always_comb begin
        nxt_state = state_ff;
        pop       = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (fifo_vld) begin
                    pop       = 1'b1;
                    nxt_state = S_HIGH;
                end
            end
            S_HIGH: begin
                if (done)
                    nxt_state = S_LOW;
            end
            S_LOW: begin
                if (!done) begin
                    nxt_state = S_LOW;
                end else if (bits_ff != BC_W'(1)) begin
                    nxt_state = S_HIGH;
                end else if (pix_ff == LEN_W'(1)) begin
                    nxt_state = S_LATCH;
                end else if (cfg_ff.pgap_en) begin
                    nxt_state = S_PGAP; // [RULE_06]
                end else if (fifo_vld) begin
                    pop       = 1'b1;
                    nxt_state = S_HIGH;
                end else begin
                    nxt_state = S_FETCH;
                end
            end
            S_PGAP, S_FETCH: begin
                if ((state_ff == S_FETCH || done) && fifo_vld) begin
                    pop       = 1'b1;
                    nxt_state = S_HIGH;
                end else if (done) begin
                    nxt_state = S_FETCH;
                end
            end
            S_LATCH: begin
                if (done)
                    nxt_state = (cfg_ff.fgap_en && first_ff) ? S_FGAP : S_IDLE; // [RULE_07]
            end
            S_FGAP: begin
                if (done)
                    nxt_state = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
        if (!cfg_ff.en) begin
            nxt_state = S_IDLE;
            pop       = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            state_ff <= S_IDLE;
        else
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            tick_ff <= 32'h0;
        else if (nxt_state != state_ff)
            tick_ff <= 32'h0;
        else
            tick_ff <= tick_ff + 32'(TPC); // [RULE_11]
    end

    // Only the high phase drives the line; everything else is low
    always_ff @(posedge clk_i) begin
        if (rst_i)
            dout_ff <= 1'b0;
        else
            dout_ff <= nxt_state == S_HIGH; // [RULE_10] [RULE_12]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shreg_ff <= '0;
            bits_ff  <= '0;
        end else if (pop) begin
            shreg_ff <= fifo_dat;
            bits_ff  <= BC_W'(PIXEL_W);
        end else if (state_ff == S_LOW && nxt_state == S_HIGH) begin
            shreg_ff <= {shreg_ff[PIXEL_W-2:0], 1'b0}; // [RULE_12]
            bits_ff  <= bits_ff - BC_W'(1);
        end
    end

    // A frame length of zero is sent as one pixel
    always_ff @(posedge clk_i) begin
        if (rst_i)
            pix_ff <= '0;
        else if (state_ff == S_IDLE && pop)
            pix_ff <= (cfg_ff.flen == '0) ? LEN_W'(1) : cfg_ff.flen;
        else if (state_ff == S_LOW && done && bits_ff == BC_W'(1))
            pix_ff <= pix_ff - LEN_W'(1);
    end

    // Restarting after disable counts as a new first frame
    always_ff @(posedge clk_i) begin
        if (rst_i)
            first_ff <= 1'b0;
        else if (!cfg_ff.en)
            first_ff <= 1'b0;
        else if (state_ff == S_LATCH && done)
            first_ff <= 1'b1;
    end

    // ========================================
    // Checks
    // Run counters let the checks measure whole intervals, not single edges
    logic [31:0] hi_cyc_ff;
    logic [31:0] st_cyc_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_cyc_ff <= 32'h0;
            st_cyc_ff <= 32'h0;
        end else begin
            hi_cyc_ff <= dout_ff ? hi_cyc_ff + 32'h1 : 32'h0;
            st_cyc_ff <= (nxt_state != state_ff) ? 32'h0 : st_cyc_ff + 32'h1;
        end
    end

    a_zero_high_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        $fell(led_data_o) && state_ff == S_LOW && !cur_bit
        |-> hi_cyc_ff == cyc_of(32'(cfg_ff.t0h)))
        else $error("zero bit high time wrong");

    a_one_high_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        $fell(led_data_o) && state_ff == S_LOW && cur_bit
        |-> hi_cyc_ff == cyc_of(32'(cfg_ff.t1h)))
        else $error("one bit high time wrong");

    a_zero_low_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
        state_ff == S_LOW && nxt_state != S_LOW && cfg_ff.en && !cur_bit
        |-> st_cyc_ff + 32'h1 == cyc_of(32'(cfg_ff.t0l)))
        else $error("zero bit low time wrong");

    a_one_low_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_04]
        state_ff == S_LOW && nxt_state != S_LOW && cfg_ff.en && cur_bit
        |-> st_cyc_ff + 32'h1 == cyc_of(32'(cfg_ff.t1l)))
        else $error("one bit low time wrong");

    a_latch_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        state_ff == S_LATCH && nxt_state != S_LATCH && cfg_ff.en
        |-> st_cyc_ff + 32'h1 == cyc_of(32'(cfg_ff.latch)) && !led_data_o)
        else $error("latch time wrong");

    a_pixel_gap: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        state_ff == S_LOW && done && bits_ff == BC_W'(1) && pix_ff != LEN_W'(1)
        && cfg_ff.en && cfg_ff.pgap_en
        |=> state_ff == S_PGAP && !led_data_o)
        else $error("pixel gap missing");

    a_first_nogap: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        state_ff == S_LATCH && done && cfg_ff.en && !first_ff
        |=> state_ff == S_IDLE ##1 first_ff)
        else $error("frame gap after first frame");

    a_tick_step: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        state_ff == $past(state_ff) && state_ff != S_IDLE && !$past(rst_i)
        |-> tick_ff == $past(tick_ff) + 32'(TPC))
        else $error("tick counter step wrong");

    a_gap_off_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        $past(rst_i) |-> !cfg_ff.pgap_en && !cfg_ff.fgap_en)
        else $error("gap enabled after reset");

    a_line_high_only: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        led_data_o |-> state_ff == S_HIGH)
        else $error("line high outside bit");

    a_msb_first: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_12]
        pop |=> cur_bit == $past(fifo_dat[PIXEL_W-1]) && state_ff == S_HIGH)
        else $error("first bit not msb");

    a_pixel_gap_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        state_ff == S_PGAP && nxt_state != S_PGAP && cfg_ff.en
        |-> st_cyc_ff + 32'h1 == cyc_of(32'(cfg_ff.pgap)) && !led_data_o)
        else $error("pixel gap time wrong");

    a_frame_gap_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        state_ff == S_FGAP && nxt_state != S_FGAP && cfg_ff.en
        |-> st_cyc_ff + 32'h1 == cyc_of(32'(cfg_ff.fgap)) && !led_data_o)
        else $error("frame gap time wrong");

    // Later frames must not skip the gap once the first has latched
    a_frame_gap_on: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        state_ff == S_LATCH && done && cfg_ff.en && cfg_ff.fgap_en && first_ff
        |=> state_ff == S_FGAP && !led_data_o)
        else $error("frame gap skipped");

    a_pixel_bits: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_10]
        pop |=> bits_ff == BC_W'(PIXEL_W) && shreg_ff == $past(fifo_dat))
        else $error("pixel not loaded whole");
endmodule
`default_nettype wire

// ===== dv/lsd_lamp_model.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Lamp chain receiver: one report per bit, high and low run lengths
module lsd_lamp_model #(
    parameter int QUIET = 64
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        line_i,
    output logic             ev_valid_o,
    output logic      [15:0] ev_hi_o,
    output logic      [15:0] ev_lo_o
);
    logic        prev_ff;
    logic        armed_ff;
    logic [15:0] hi_ff;
    logic [15:0] lo_ff;

    // No clock line, so a bit is known only from its run lengths
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff    <= 1'b0;
            armed_ff   <= 1'b0;
            hi_ff      <= 16'h0000;
            lo_ff      <= 16'h0000;
            ev_valid_o <= 1'b0;
            ev_hi_o    <= 16'h0000;
            ev_lo_o    <= 16'h0000;
        end else begin
            prev_ff    <= line_i;
            ev_valid_o <= 1'b0;
            if (line_i && !prev_ff) begin
                ev_valid_o <= armed_ff;
                ev_hi_o    <= hi_ff;
                ev_lo_o    <= lo_ff;
                armed_ff   <= 1'b1;
                hi_ff      <= 16'h0001;
                lo_ff      <= 16'h0000;
            end else if (line_i) begin
                hi_ff <= hi_ff + 16'h0001;
            end else begin
                lo_ff <= lo_ff + 16'h0001;
                // Last bit of a burst has no next rise; a long quiet closes it
                if (armed_ff && lo_ff == 16'(QUIET - 1)) begin
                    ev_valid_o <= 1'b1;
                    ev_hi_o    <= hi_ff;
                    ev_lo_o    <= 16'(QUIET);
                    armed_ff   <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/lsd_led_strip_driver_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module lsd_led_strip_driver_tb import lsd_pkg::*;;
    localparam int QUIET = 64;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo_min;
        logic [15:0] lo_max;
    } lsd_run_type;
    logic             clk_i  = 1'b0;
    logic             rst_i  = 1'b1;
    logic             wb_cyc = 1'b0;
    logic             wb_stb = 1'b0;
    logic             wb_we  = 1'b0;
    logic [ADR_W-1:0] wb_adr = 8'h00;
    logic [3:0]       wb_sel = 4'hF;
    logic [31:0]      wb_dat = 32'h0;
    logic [31:0]      wb_rdat;
    logic             wb_ack;
    logic             led_line;
    logic             ev_valid;
    logic [15:0]      ev_hi;
    logic [15:0]      ev_lo;
    logic [31:0]      rexp;
    logic             in_rng;
    lsd_run_type      run;
    logic [31:0]      rd_q[$];
    lsd_run_type      led_q[$];
    logic [PIX_W-1:0] pend_q[$];
    int               err_total = 0;
    int               tests_run = 0;
    int               cyc_cnt   = 0;
    int               hi0, lo0, hi1, lo1, lat, pg, fg, t0;

    lsd_led_strip_driver #(.PIXEL_W(PIX_W), .FIFO_DEPTH(8)) lsd_led_strip_driver_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .led_data_o(led_line));
    lsd_lamp_model #(.QUIET(QUIET)) lsd_lamp_model_i (
        .clk_i(clk_i), .rst_i(rst_i), .line_i(led_line),
        .ev_valid_o(ev_valid), .ev_hi_o(ev_hi), .ev_lo_o(ev_lo));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // ========================================
    // Bus and planning tasks
    task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
        {wb_adr, wb_dat} <= {adr, dat};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask
    task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask
    task automatic rd(input logic [ADR_W-1:0] adr, input logic [31:0] ex);
        rd_q.push_back(ex);
        wb_xfer(1'b0, adr, 32'h0);
    endtask
    function automatic int cyc(input int t);
        return (t == 0) ? 1 : (t + TPC - 1) / TPC;
    endfunction
    task automatic set_bits(input int a, input int b, input int c, input int d);
        wr(REG_BITT, {8'(d), 8'(c), 8'(b), 8'(a)});
        rd(REG_BITT, {8'(d), 8'(c), 8'(b), 8'(a)});
        hi0 = cyc(a);
        lo0 = cyc(b);
        hi1 = cyc(c);
        lo1 = cyc(d);
    endtask
    task automatic gen(input int n);
        pend_q.delete();
        repeat (n) pend_q.push_back(PIX_W'($urandom()));
    endtask
    task automatic send(input int a, input int b);
        for (int i = a; i < b; i++) wr(REG_DATA, 32'(pend_q[i]));
    endtask
    // Pixel ends allow a few fetch cycles; bit ends inside a pixel are exact
    task automatic plan_frames(input int flen);
        int lo;
        int mx;
        for (int k = 0; k < pend_q.size(); k++) begin
            for (int b = PIX_W - 1; b >= 0; b--) begin
                lo = pend_q[k][b] ? lo1 : lo0;
                if (b == 0)
                    lo = lo + ((k % flen == flen - 1) ? lat + ((k >= flen) ? fg : 0) : pg);
                mx = (b != 0) ? lo : (k == pend_q.size() - 1) ? QUIET : lo + 4;
                led_q.push_back(lsd_run_type'{16'(pend_q[k][b] ? hi1 : hi0),
                                              16'(lo), 16'(mx)});
            end
        end
    endtask
    task automatic drain;
        while (led_q.size() > 0) @(posedge clk_i);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ========================================
    // Result watchers
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
            rexp = rd_q.pop_front();
            `CHK("register read", rexp, wb_rdat)
        end
    end
    always @(posedge clk_i) begin
        if (ev_valid === 1'b1) begin
            run = (led_q.size() > 0) ? led_q.pop_front() : '0;
            in_rng = (ev_lo >= run.lo_min && ev_lo <= run.lo_max);
            `CHK("high run", run.hi, ev_hi)
            `CHK("low run", 1'b1, in_rng)
        end
    end
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            err_total++;
            $display("wrong value run length expected done seen stuck");
            tally_and_finish();
        end
    end

    // ========================================
    // Scenarios
    initial begin
        void'($urandom(32'h5D90));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("idle line", 1'b0, led_line)
        rd(REG_CTRL, 32'h0);
        rd(REG_BITT, 32'h0C20200C);
        rd(REG_LATCH, 32'h0000000C);
        rd(REG_STAT, 32'h00000002);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0);
        wr(REG_STAT, 32'hFFFFFFFF);
        rd(REG_STAT, 32'h00000002);
        // Reset timing drives the first frame, so BITT is not written here
        hi0 = cyc(12);
        lo0 = cyc(32);
        hi1 = cyc(32);
        lo1 = cyc(12);
        lat = cyc(12);
        pg = 0;
        fg = 0;
        wr(REG_FLEN, 32'h00000002);
        gen(2);
        plan_frames(2);
        send(0, 2);
        wr(REG_CTRL, 32'h00000001);
        drain();
        rd(REG_STAT, 32'h0000000A);
        `CHK("idle line", 1'b0, led_line)
        // Disable restarts the first-frame count, so the gap skip is seen again
        wr(REG_CTRL, 32'h0);
        set_bits($urandom_range(9, 1), $urandom_range(9, 1), $urandom_range(9, 1),
                 $urandom_range(9, 1));
        wr(REG_LATCH, 32'hFFFFFFFF);
        rd(REG_LATCH, 32'h00003FFF);
        wr(REG_LATCH, 32'h0000000D);
        wr(REG_PGAP, 32'hFFFFFFFF);
        rd(REG_PGAP, 32'h000001FF);
        wr(REG_PGAP, 32'h00000007);
        wr(REG_FGAP, 32'hFFFFFFFF);
        rd(REG_FGAP, 32'h7FFFFFFF);
        wr(REG_FGAP, 32'h00000028);
        lat = cyc(13);
        pg = cyc(7);
        fg = cyc(40);
        gen(6);
        plan_frames(2);
        send(0, 6);
        wr(REG_CTRL, 32'h00000007);
        drain();
        // Ten pixels through eight slots: the tenth write must wait
        wr(REG_CTRL, 32'h0);
        pg = 0;
        fg = 0;
        wr(REG_FLEN, 32'h0000000A);
        gen(10);
        plan_frames(10);
        wr(REG_CTRL, 32'h00000001);
        send(0, 9);
        rd(REG_STAT, 32'h00000005);
        t0 = cyc_cnt;
        send(9, 10);
        `CHK("full stall", 1'b1, (cyc_cnt - t0 > 20))
        drain();
        rd(REG_STAT, 32'h0000000A);
        repeat (4) @(posedge clk_i);
        tally_and_finish();
    end
endmodule
`default_nettype wire
